// *** shared/csf_pkg.sv ***
package csf_pkg;

  // Positions of the sampled pins in the sampler vectors
  localparam int PIN_CLK  = 0;
  localparam int PIN_XTAL = 1;
  localparam int PIN_SEL  = 2;
  localparam int PIN_EN   = 3;
  localparam int PIN_N    = 4;

  // Undriven-pin levels: enable high, select crystal, clock low
  localparam logic [PIN_N-1:0] PIN_DEFAULT = 4'hc;
  localparam logic             GATE_RESET  = 1'h1;

  typedef enum logic [1:0] {
    CSF_IDLE      = 2'b00,
    CSF_WAIT_RISE = 2'b01,
    CSF_WAIT_FALL = 2'b10
  } csf_gate_st_t;

  // Pin samplers: three stages and the agreed level
  typedef struct packed {
    logic [PIN_N-1:0] s1;
    logic [PIN_N-1:0] s2;
    logic [PIN_N-1:0] s3;
    logic [PIN_N-1:0] filt;
  } csf_sync_t;

  // Output levels
  typedef struct packed {
    logic       diff_true;
    logic       diff_comp;
    logic [2:0] se;
    logic       xtal_drive;
  } csf_outs_t;

  typedef struct packed {
    csf_sync_t    sync;
    logic         src;
    csf_gate_st_t gst;
    logic         gate;
    csf_outs_t    outs;
  } csf_state_t;

  localparam csf_outs_t OUTS_RESET = '{diff_true: 1'h0, diff_comp: 1'h1, se: 3'h0, xtal_drive: 1'h1};

endpackage

// *** core/csf_fanout.sv ***
// Notes on behaviour
// - Select high picks crystal, low picks clock
// - Enabled outputs follow the selected source
// - Disabled: true outputs low, complement high
// - New enable applies after rise then fall
// - Enable synchronised; asynchronous changes, no runts
// - Selected source high while enabled: true high, complement low
// - Undriven pins: enable high, crystal, clock low
// - One source fanned to four outputs
`timescale 1ns/1ns
`default_nettype none
module csf_fanout
  import csf_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Source and control pins
  input  wire logic       clock_in,
  input  wire logic       crystal_in,
  input  wire logic       source_sel,
  input  wire logic       out_enable,
  // Crystal drive
  output logic            crystal_out,
  // Clock outputs
  output logic            diff_out_true,
  output logic            diff_out_comp,
  output logic [2:0]      se_out
);

  csf_state_t st_ff;
  csf_state_t nxt_st;

  logic [PIN_N-1:0] pins;
  logic [PIN_N-1:0] agree;
  logic             en_now;

  assign pins = {out_enable, source_sel, crystal_in, clock_in};

  always_comb begin
    nxt_st = st_ff;
    agree  = ~(st_ff.sync.s2 ^ st_ff.sync.s3);
    nxt_st.sync.s1 = pins;
    nxt_st.sync.s2 = st_ff.sync.s1;
    nxt_st.sync.s3 = st_ff.sync.s2;
    nxt_st.sync.filt = (agree & st_ff.sync.s3) | (~agree & st_ff.sync.filt);
    en_now = st_ff.sync.filt[PIN_EN];
    // Source choice
    nxt_st.src = st_ff.sync.filt[PIN_SEL] ? st_ff.sync.filt[PIN_XTAL] : st_ff.sync.filt[PIN_CLK];
    // Enable takes effect after a rising then a falling source edge
    case (st_ff.gst)
      CSF_IDLE: begin
        if (en_now != st_ff.gate) begin
          nxt_st.gst = CSF_WAIT_RISE;
        end
      end
      CSF_WAIT_RISE: begin
        if (!st_ff.src && nxt_st.src) begin
          nxt_st.gst = CSF_WAIT_FALL;
        end
      end
      CSF_WAIT_FALL: begin
        if (st_ff.src && !nxt_st.src) begin
          nxt_st.gate = en_now;
          nxt_st.gst  = CSF_IDLE;
        end
      end
      default: begin
        nxt_st.gst = CSF_IDLE;
      end
    endcase
    nxt_st.outs.diff_true  = nxt_st.gate & nxt_st.src;
    nxt_st.outs.diff_comp  = ~(nxt_st.gate & nxt_st.src);
    nxt_st.outs.se         = {3{nxt_st.gate & nxt_st.src}};
    nxt_st.outs.xtal_drive = ~st_ff.sync.filt[PIN_XTAL];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff.sync.s1   <= PIN_DEFAULT;
      st_ff.sync.s2   <= PIN_DEFAULT;
      st_ff.sync.s3   <= PIN_DEFAULT;
      st_ff.sync.filt <= PIN_DEFAULT;
      st_ff.src       <= 1'h0;
      st_ff.gst       <= CSF_IDLE;
      st_ff.gate      <= GATE_RESET;
      st_ff.outs      <= OUTS_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign crystal_out   = st_ff.outs.xtal_drive;
  assign diff_out_true = st_ff.outs.diff_true;
  assign diff_out_comp = st_ff.outs.diff_comp;
  assign se_out        = st_ff.outs.se;

  // Checks
  src_route_a: assert property (@(posedge clk) disable iff (!rstn)
    ##1 st_ff.src == ($past(st_ff.sync.filt[PIN_SEL]) ? $past(st_ff.sync.filt[PIN_XTAL])
                                                      : $past(st_ff.sync.filt[PIN_CLK])))
    else $error("Source does not match select");
  out_follow_a: assert property (@(posedge clk) disable iff (!rstn)
    st_ff.gate |-> diff_out_true == st_ff.src)
    else $error("Enabled output does not follow source");
  dis_levels_a: assert property (@(posedge clk) disable iff (!rstn)
    !st_ff.gate |-> !diff_out_true && diff_out_comp && se_out == 3'h0)
    else $error("Disabled output levels wrong");
  gate_order_a: assert property (@(posedge clk) disable iff (!rstn)
    $changed(st_ff.gate) |-> $past(st_ff.gst) == CSF_WAIT_FALL && $past(st_ff.src))
    else $error("Gate changed without rise and fall");
  gate_sync_a: assert property (@(posedge clk) disable iff (!rstn)
    $changed(st_ff.gate) |-> st_ff.gate == $past(st_ff.sync.filt[PIN_EN]))
    else $error("Gate took a level other than the filtered enable");
  pair_comp_a: assert property (@(posedge clk) disable iff (!rstn)
    diff_out_comp == !diff_out_true)
    else $error("Complement not opposite of true output");
  fan_same_a: assert property (@(posedge clk) disable iff (!rstn)
    se_out == {3{diff_out_true}})
    else $error("Fanout outputs disagree");
  gate_low_a: assert property (@(posedge clk) disable iff (!rstn)
    $changed(st_ff.gate) |-> !st_ff.src && !diff_out_true && $past(st_ff.src))
    else $error("Gate changed while source high");

  sync_first_a: assert property (
    @(posedge clk) disable iff (!rstn)
    1'b1 |=> st_ff.sync.s1 == $past(pins))
    else $error("First sampler stage lost a pin");

  sync_second_a: assert property (
    @(posedge clk) disable iff (!rstn)
    1'b1 |=> st_ff.sync.s2 == $past(st_ff.sync.s1))
    else $error("Second sampler stage lost a pin");

  sync_third_a: assert property (
    @(posedge clk) disable iff (!rstn)
    1'b1 |=> st_ff.sync.s3 == $past(st_ff.sync.s2))
    else $error("Third sampler stage lost a pin");

  en_keep_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_ff.sync.s2[PIN_EN] != st_ff.sync.s3[PIN_EN]) |=> $stable(st_ff.sync.filt[PIN_EN]))
    else $error("Enable filter moved without agreement");

  en_take_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_ff.sync.s2[PIN_EN] == st_ff.sync.s3[PIN_EN]) |=> st_ff.sync.filt[PIN_EN] == $past(st_ff.sync.s3[PIN_EN]))
    else $error("Enable filter missed an agreed level");

  sel_keep_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_ff.sync.s2[PIN_SEL] != st_ff.sync.s3[PIN_SEL]) |=> $stable(st_ff.sync.filt[PIN_SEL]))
    else $error("Select filter moved without agreement");

  sel_take_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_ff.sync.s2[PIN_SEL] == st_ff.sync.s3[PIN_SEL]) |=> st_ff.sync.filt[PIN_SEL] == $past(st_ff.sync.s3[PIN_SEL]))
    else $error("Select filter missed an agreed level");

  clk_route_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !st_ff.sync.filt[PIN_SEL] |=> st_ff.src == $past(st_ff.sync.filt[PIN_CLK]))
    else $error("Clock pin not routed when select low");

  xtal_route_a: assert property (
    @(posedge clk) disable iff (!rstn)
    st_ff.sync.filt[PIN_SEL] |=> st_ff.src == $past(st_ff.sync.filt[PIN_XTAL]))
    else $error("Crystal not routed when select high");

  xtal_drive_a: assert property (
    @(posedge clk) disable iff (!rstn)
    1'b1 |=> crystal_out == !$past(st_ff.sync.filt[PIN_XTAL]))
    else $error("Crystal drive not inverse of crystal input");

  idle_hold_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_ff.gst == CSF_IDLE && st_ff.sync.filt[PIN_EN] == st_ff.gate) |=> st_ff.gst == CSF_IDLE)
    else $error("Gate sequence started without enable change");

  idle_leave_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_ff.gst == CSF_IDLE && st_ff.sync.filt[PIN_EN] != st_ff.gate) |=> st_ff.gst == CSF_WAIT_RISE)
    else $error("Enable change did not start the sequence");

  rise_wait_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_ff.gst == CSF_WAIT_RISE) |=> st_ff.gst inside {CSF_WAIT_RISE, CSF_WAIT_FALL})
    else $error("Rise wait left without a rise");

  rise_seen_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_ff.gst == CSF_WAIT_RISE && !st_ff.src) ##1 st_ff.src |-> st_ff.gst == CSF_WAIT_FALL)
    else $error("Source rise not taken");

  fall_seen_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_ff.gst == CSF_WAIT_FALL && st_ff.src) ##1 !st_ff.src |-> st_ff.gst == CSF_IDLE)
    else $error("Source fall did not end the sequence");

  gate_hold_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_ff.gst != CSF_WAIT_FALL) |=> $stable(st_ff.gate))
    else $error("Gate moved outside the fall wait");

  gst_legal_a: assert property (
    @(posedge clk) disable iff (!rstn)
    st_ff.gst inside {CSF_IDLE, CSF_WAIT_RISE, CSF_WAIT_FALL})
    else $error("Gate sequence in an unused state");

  gate_on_low_a: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(st_ff.gate) |-> !st_ff.src && !diff_out_true)
    else $error("Gate opened while source high");

  comp_high_a: assert property (
    @(posedge clk) disable iff (!rstn)
    diff_out_true |-> !diff_out_comp && se_out == 3'h7)
    else $error("High source levels wrong");

endmodule // csf_fanout
`default_nettype wire

// *** verification/csf_src_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module csf_src_model (
  // Control
  input  wire logic run,
  // Sources
  output logic      clock_in,
  output logic      crystal_in
);
  initial begin
    clock_in = 1'h0;
    crystal_in = 1'h0;
  end
  always #1600 if (run) clock_in = ~clock_in;
  always #1100 if (run) crystal_in = ~crystal_in;
endmodule // csf_src_model
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import csf_pkg::*;
  logic       clk, rstn, run, sel, en, xo, dt, dc, ci, xi, xi_q;
  logic [2:0] se;
  int         fails, total_checks, hi_len, exp_len, n_pulse, xi_age;
  csf_src_model i_src (.run(run), .clock_in(ci), .crystal_in(xi));
  csf_fanout i_dut (.clk(clk), .rstn(rstn), .clock_in(ci), .crystal_in(xi), .source_sel(sel), .out_enable(en),
    .crystal_out(xo), .diff_out_true(dt), .diff_out_comp(dc), .se_out(se));
  always #50 clk = ~clk;
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Outputs agree; every high pulse is whole
  always @(negedge clk) begin
    if (rstn) begin
      check({1'h0, dc, se}, {1'h0, ~dt, {3{dt}}});
      if (xi !== xi_q) xi_age = 0;
      else xi_age++;
      xi_q = xi;
      if (xi_age >= 7) check({4'h0, xo}, {4'h0, ~xi});
      if (dt) hi_len++;
      else if (hi_len != 0) begin
        check(hi_len[4:0], exp_len[4:0]);
        n_pulse++;
        hi_len = 0;
      end
    end
  end
  // Gate off, switch source, gate on, glitch the enable
  task automatic run_src(input logic s);
    en = 1'h0;
    repeat (60) @(negedge clk);
    check({dt, dc, se}, 5'h08);
    sel = s;
    exp_len = s ? 11 : 16;
    repeat (10) @(negedge clk);
    check({dt, dc, se}, 5'h08);
    n_pulse = 0;
    en = 1'h1;
    repeat (100) @(negedge clk);
    en = 1'h0;
    repeat (3) @(negedge clk);
    en = 1'h1;
    repeat (100) @(negedge clk);
    check(5'(n_pulse >= 3), 5'h01);
  endtask
  initial begin
    {clk, rstn, run, sel, en} = 5'h07;
    {fails, total_checks, hi_len, n_pulse, xi_age} = '0;
    xi_q = 1'h0;
    exp_len = 11;
    repeat (5) @(negedge clk);
    rstn = 1'h1;
    run_src(1'h0);
    run_src(1'h1);
    wrap_up();
  end
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
